/* verilog/pld_pkg.sv */
// Shared constants, field layout and carrier types for the output macrocell array.
package pld_pkg;

    localparam int unsigned NUM_CELLS  = 12;
    localparam int unsigned MAX_TERMS  = 12;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned OE_FIELD_W = 2;

    // Register byte offsets on the APB port.
    localparam logic [ADDR_W-1:0] ADDR_MODE    = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_POL     = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_OE      = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_PRELOAD = 12'h00C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = 12'h010;

    // Status word layout: stored register values, then synchronised pin levels.
    localparam int unsigned STAT_Q_LSB   = 0;
    localparam int unsigned STAT_PIN_LSB = 12;

    // Per-cell configuration encodings.
    localparam logic       MODE_REGISTERED = 1'b1;
    localparam logic       POL_TRUE        = 1'b1;
    localparam logic [1:0] OE_TERM         = 2'h0;
    localparam logic [1:0] OE_ON           = 2'h1;
    localparam logic [1:0] OE_OFF          = 2'h2;

    // Reset values: combinatorial, true polarity, every pin a dedicated input.
    localparam logic [NUM_CELLS-1:0]              MODE_RST    = 12'h000;
    localparam logic [NUM_CELLS-1:0]              POL_RST     = 12'hFFF;
    localparam logic [NUM_CELLS*OE_FIELD_W-1:0]   OE_RST      = 24'hAA_AAAA;
    localparam logic [NUM_CELLS-1:0]              PRELOAD_RST = 12'h000;

    // Product terms feeding the macrocells, straight from the AND array.
    typedef struct packed {
        logic [NUM_CELLS-1:0][MAX_TERMS-1:0] logic_term;
        logic [NUM_CELLS-1:0]                oe_term;
        logic                                shared_async_clear_term;
        logic                                shared_sync_set_term;
    } pld_terms_s;

    // Feedback returned to the AND array, true and complemented.
    typedef struct packed {
        logic [NUM_CELLS-1:0] fb_true;
        logic [NUM_CELLS-1:0] fb_comp;
    } pld_fb_s;

    // Number of logic product terms summed by each macrocell.
    function automatic int unsigned cell_terms(input int unsigned idx);
        case (idx)
            4, 7:    return 10;
            5, 6:    return 12;
            default: return 8;
        endcase
    endfunction : cell_terms

endpackage : pld_pkg

/* verilog/pld_macrocell.sv */
// One configurable output macrocell: sum term, flip-flop, polarity, enable and feedback.
`timescale 1ns/10ps
module pld_macrocell
    import pld_pkg::*;
#(
    parameter int unsigned TERMS = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear_term,
    input  wire logic             set_term,
    input  wire logic             preload_en,
    input  wire logic             preload_val,
    input  wire logic [TERMS-1:0] logic_terms,
    input  wire logic             oe_term,
    input  wire logic             mode,
    input  wire logic             polarity,
    input  wire logic [1:0]       oe_sel,
    input  wire logic             pin_level,
    output logic                  pin_out,
    output logic                  pin_oe_n,
    output logic                  fb_true,
    output logic                  fb_comp,
    output logic                  q,
    output logic                  sum
);

    logic q_ff;
    logic cell_clr_n;
    logic data_sel;
    logic oe;

    assign sum = |logic_terms;

    // The clear term joins the power-up reset, so it wins over any edge.
    assign cell_clr_n = rst_n & ~clear_term;

    always_ff @(posedge clk or negedge cell_clr_n) begin
        if (!cell_clr_n) begin
            q_ff <= 1'b0;
        end else if (preload_en) begin
            q_ff <= preload_val;
        end else if (set_term) begin
            q_ff <= 1'b1;
        end else begin
            q_ff <= sum;
        end
    end

    assign q        = q_ff;
    assign data_sel = (mode == MODE_REGISTERED) ? q_ff : sum;
    assign pin_out  = (polarity == POL_TRUE) ? data_sel : ~data_sel;

    always_comb begin
        if (mode == MODE_REGISTERED) begin
            oe = oe_term;
        end else begin
            case (oe_sel)
                OE_ON:   oe = 1'b1;
                OE_OFF:  oe = 1'b0;
                default: oe = oe_term;
            endcase
        end
    end

    assign pin_oe_n = ~oe;

    // A registered cell never looks at its pin, so it cannot be used as an input.
    always_comb begin
        if (mode == MODE_REGISTERED) begin
            fb_true = ~q_ff;
            fb_comp = q_ff;
        end else begin
            fb_true = pin_level;
            fb_comp = ~pin_level;
        end
    end

endmodule : pld_macrocell

/* verilog/pld_output_macrocell_array.sv */
// Twelve output macrocells with an APB configuration and test preload port.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - Cells sum twelve, ten or eight terms.
// - Each cell has a dedicated enable term.
// - Polarity per cell, true or inverted.
// - Shared clear term zeroes registers immediately.
// - Shared set term loads ones at edge.
// - Clear and set ignore output polarity.
// - Two config bits pick mode, polarity.
// - Registered pin driven from stored value.
// - Registered feedback is inverted stored value, both forms.
// - Registered pin is output only.
// - Combinatorial pin driven straight from sum.
// - Combinatorial enable: on, off, or term.
// - Combinatorial feedback taken from pin level.
// - Power-up clears all registers to zero.
// - Preload forces any register state synchronously.
module pld_output_macrocell_array
    import pld_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire pld_terms_s        terms,
    input  wire logic [NUM_CELLS-1:0] pin_in,
    output logic [NUM_CELLS-1:0]   pin_out,
    output logic [NUM_CELLS-1:0]   pin_oe_n,
    output pld_fb_s                array_fb
);

    logic [NUM_CELLS-1:0]            cell_mode_bit_ff;
    logic [NUM_CELLS-1:0]            cell_polarity_bit_ff;
    logic [NUM_CELLS*OE_FIELD_W-1:0] oe_sel_ff;
    logic                            preload_en_ff;
    logic [NUM_CELLS-1:0]            preload_val_ff;
    logic [NUM_CELLS-1:0]            pin_meta_ff;
    logic [NUM_CELLS-1:0]            pin_sync_ff;
    logic [31:0]                     prdata_ff;
    logic                            pslverr_ff;
    logic [NUM_CELLS-1:0]            cell_q;
    logic [NUM_CELLS-1:0]            cell_sum;
    logic [NUM_CELLS-1:0]            fb_true_w;
    logic [NUM_CELLS-1:0]            fb_comp_w;
    logic                            apb_setup;
    logic                            apb_wr;
    logic [31:0]                     rd_data;
    logic                            rd_hit;

    // Zero wait states: every access phase completes in its first cycle.
    assign pready    = 1'b1;
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign prdata    = prdata_ff;
    assign pslverr   = pslverr_ff;

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            ADDR_MODE:    rd_data = 32'(cell_mode_bit_ff);
            ADDR_POL:     rd_data = 32'(cell_polarity_bit_ff);
            ADDR_OE:      rd_data = 32'(oe_sel_ff);
            ADDR_PRELOAD: rd_data = 32'(preload_val_ff);
            ADDR_STATUS:  rd_data = 32'({pin_sync_ff, cell_q});
            default:      rd_hit  = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle so prdata comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_ff <= ~rd_hit;
        end else begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_mode_bit_ff     <= MODE_RST;
            cell_polarity_bit_ff <= POL_RST;
            oe_sel_ff            <= OE_RST;
        end else if (apb_wr) begin
            case (paddr)
                ADDR_MODE: cell_mode_bit_ff     <= pwdata[NUM_CELLS-1:0];
                ADDR_POL:  cell_polarity_bit_ff <= pwdata[NUM_CELLS-1:0];
                ADDR_OE:   oe_sel_ff            <= pwdata[NUM_CELLS*OE_FIELD_W-1:0];
                default:   ;
            endcase
        end
    end

    // A preload write becomes a one-cycle force applied at the following edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preload_en_ff  <= 1'b0;
            preload_val_ff <= PRELOAD_RST;
        end else begin
            preload_en_ff <= apb_wr && (paddr == ADDR_PRELOAD);
            if (apb_wr && (paddr == ADDR_PRELOAD)) begin
                preload_val_ff <= pwdata[NUM_CELLS-1:0];
            end
        end
    end

    // Pins are driven by board logic on its own timing, so they are synchronised.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pin_in;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
        localparam int unsigned N = cell_terms(i);
        pld_macrocell #(
            .TERMS (N)
        ) u_cell (
            .clk         (pclk),
            .rst_n       (presetn),
            .clear_term  (terms.shared_async_clear_term),
            .set_term    (terms.shared_sync_set_term),
            .preload_en  (preload_en_ff),
            .preload_val (preload_val_ff[i]),
            .logic_terms (terms.logic_term[i][N-1:0]),
            .oe_term     (terms.oe_term[i]),
            .mode        (cell_mode_bit_ff[i]),
            .polarity    (cell_polarity_bit_ff[i]),
            .oe_sel      (oe_sel_ff[OE_FIELD_W*i +: OE_FIELD_W]),
            .pin_level   (pin_sync_ff[i]),
            .pin_out     (pin_out[i]),
            .pin_oe_n    (pin_oe_n[i]),
            .fb_true     (fb_true_w[i]),
            .fb_comp     (fb_comp_w[i]),
            .q           (cell_q[i]),
            .sum         (cell_sum[i])
        );
    end

    assign array_fb.fb_true = fb_true_w;
    assign array_fb.fb_comp = fb_comp_w;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic clr_w;
    logic set_w;
    assign clr_w = terms.shared_async_clear_term;
    assign set_w = terms.shared_sync_set_term;

    // Per-cell view of the enable codes, used only by the checks below.
    // The codes are decoded again here so the checks do not lean on the cell's own decoder.
    logic [NUM_CELLS-1:0] sel_on_w;
    logic [NUM_CELLS-1:0] sel_off_w;

    always_comb begin
        sel_on_w  = '0;
        sel_off_w = '0;
        for (int c = 0; c < NUM_CELLS; c++) begin
            sel_on_w[c]  = (oe_sel_ff[OE_FIELD_W*c +: OE_FIELD_W] == OE_ON);
            sel_off_w[c] = (oe_sel_ff[OE_FIELD_W*c +: OE_FIELD_W] == OE_OFF);
        end
    end

    power_up_clear_a: assert property ($rose(presetn) |-> cell_q == '0)
        else $error("registers not cleared after power-up reset");

    clear_zero_a: assert property (clr_w |-> cell_q == '0)
        else $error("clear term did not zero the registers");

    clear_wins_a: assert property ((clr_w && set_w) |-> ##1 (clr_w || cell_q != '1) ##0 $past(cell_q) == '0)
        else $error("set overrode an active clear");

    set_loads_a: assert property ((set_w && !clr_w && !preload_en_ff) |=> (clr_w || cell_q == '1))
        else $error("set term did not load ones");

    preload_force_a: assert property ((preload_en_ff && !clr_w) |=> (clr_w || cell_q == $past(preload_val_ff)))
        else $error("preload value not forced into registers");

    data_load_a: assert property ((!set_w && !clr_w && !preload_en_ff) |=> (clr_w || cell_q == $past(cell_sum)))
        else $error("register did not load its sum term");

    reg_pin_a: assert property ((((pin_out ^ ~cell_polarity_bit_ff) ^ cell_q) & cell_mode_bit_ff) == '0)
        else $error("registered pin does not follow stored value and polarity");

    comb_pin_a: assert property ((((pin_out ^ ~cell_polarity_bit_ff) ^ cell_sum) & ~cell_mode_bit_ff) == '0)
        else $error("combinatorial pin does not follow sum and polarity");

    reg_fb_a: assert property (((fb_true_w ^ ~cell_q) & cell_mode_bit_ff) == '0 && (fb_comp_w ^ fb_true_w) == '1)
        else $error("registered feedback is not the inverted stored value");

    comb_fb_a: assert property (((fb_true_w ^ pin_sync_ff) & ~cell_mode_bit_ff) == '0)
        else $error("combinatorial feedback does not follow the pin");

    reg_oe_a: assert property (((~pin_oe_n ^ terms.oe_term) & cell_mode_bit_ff) == '0)
        else $error("registered output enable not from its term");

    comb_off_a: assert property ((!cell_mode_bit_ff[0] && oe_sel_ff[1:0] == OE_OFF) |-> pin_oe_n[0])
        else $error("dedicated input cell drives its pin");

    cfg_write_a: assert property ((apb_wr && paddr == ADDR_MODE) |=> cell_mode_bit_ff == $past(pwdata[NUM_CELLS-1:0]))
        else $error("mode register write not taken");

    // Enable checks cover every cell, not just cell zero.
    comb_on_a: assert property ((~cell_mode_bit_ff & sel_on_w & pin_oe_n) == '0)
        else $error("dedicated output cell does not drive its pin");

    comb_off_all_a: assert property ((~cell_mode_bit_ff & sel_off_w & ~pin_oe_n) == '0)
        else $error("dedicated input cell drives its pin");

    comb_term_a: assert property ((~cell_mode_bit_ff & ~sel_on_w & ~sel_off_w & (~pin_oe_n ^ terms.oe_term)) == '0)
        else $error("dynamic cell enable not from its term");

    comb_fb_comp_a: assert property (((fb_comp_w ^ ~pin_sync_ff) & ~cell_mode_bit_ff) == '0)
        else $error("combinatorial complement feedback does not follow the pin");

    reg_no_pin_a: assert property (((fb_comp_w ^ cell_q) & cell_mode_bit_ff) == '0)
        else $error("registered feedback does not come from the register");

    pol_write_a: assert property ((apb_wr && paddr == ADDR_POL) |=> cell_polarity_bit_ff == $past(pwdata[NUM_CELLS-1:0]))
        else $error("polarity register write not taken");

    oe_write_a: assert property ((apb_wr && paddr == ADDR_OE) |=> oe_sel_ff == $past(pwdata[NUM_CELLS*OE_FIELD_W-1:0]))
        else $error("enable register write not taken");

    pol_read_a: assert property ((apb_setup && !pwrite && paddr == ADDR_POL) |=> prdata == 32'(cell_polarity_bit_ff))
        else $error("polarity register read returned wrong data");

    bad_addr_a: assert property ((apb_setup && paddr > ADDR_STATUS) |=> pslverr)
        else $error("unmapped address not flagged");

    // A cleared register shows the inverse of its polarity bit on the pin.
    clear_pin_a: assert property (clr_w |-> ((pin_out ^ ~cell_polarity_bit_ff) & cell_mode_bit_ff) == '0)
        else $error("cleared registered pin does not follow polarity");

    set_pin_a: assert property ((set_w && !clr_w && !preload_en_ff) |=> (clr_w || ((pin_out ^ ~cell_polarity_bit_ff) & cell_mode_bit_ff) == cell_mode_bit_ff))
        else $error("set registered pin does not follow polarity");

    set_seen_c: cover property (set_w && !clr_w ##1 cell_q == '1);
    clear_seen_c: cover property (cell_q != '0 ##1 clr_w);
    preload_seen_c: cover property (preload_en_ff ##1 cell_q != '0);
    dyn_io_c: cover property (!cell_mode_bit_ff[0] && oe_sel_ff[1:0] == OE_TERM && $fell(pin_oe_n[0]));
    mode_switch_c: cover property ($rose(cell_mode_bit_ff[0]));

endmodule : pld_output_macrocell_array

/* sim/pld_board_model.sv */
// Board-side model of the pins: drives released pins or lets the pull-up win.
`timescale 1ns/10ps
module pld_board_model
    import pld_pkg::*;
(
    input  wire logic [NUM_CELLS-1:0] pin_out,
    input  wire logic [NUM_CELLS-1:0] pin_oe_n,
    input  wire logic [NUM_CELLS-1:0] drive_en,
    input  wire logic [NUM_CELLS-1:0] drive_val,
    output logic [NUM_CELLS-1:0]      pin_in
);
    // A clash is resolved in favour of the cell, so a fight never shows up as an unknown level.
    always_comb begin
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (drive_en[i]) begin
                pin_in[i] = drive_val[i];
            end else begin
                pin_in[i] = 1'b1;
            end
        end
    end
endmodule : pld_board_model

/* sim/tb_top.sv */
// Self-checking bench: APB configuration, random product terms and pin checks.
`timescale 1ns/10ps
module tb_top
    import pld_pkg::*;
;
    localparam int CNT [NUM_CELLS] = '{8, 8, 8, 8, 10, 12, 12, 10, 8, 8, 8, 8};
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, pl_go;
    logic [ADDR_W-1:0]    paddr;
    logic [31:0]          pwdata, prdata;
    pld_terms_s           terms;
    pld_fb_s              array_fb;
    logic [NUM_CELLS-1:0] pin_in, pin_out, pin_oe_n, drv_en, drv_val, m_mode, m_pol, m_q, pl_val;
    logic [23:0]          m_oe;
    logic [191:0]         rnd;
    logic [32:0]          bus_q[$];
    logic [47:0]          pin_q[$];
    event                 pin_ev;
    int                   num_errors, n_tests, cyc;

    pld_output_macrocell_array uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .terms(terms), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .array_fb(array_fb));
    pld_board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive_en(drv_en), .drive_val(drv_val),
        .pin_in(pin_in));

    always #4 pclk = ~pclk;

    function automatic logic fsum(input int i);
        return |(terms.logic_term[i] & ((12'h001 << CNT[i]) - 12'h001));
    endfunction : fsum

    function automatic logic [47:0] calc();
        logic [NUM_CELLS-1:0] o, n, t;
        logic [1:0]           code;
        for (int i = 0; i < NUM_CELLS; i++) begin
            code = m_oe[2*i+:2];
            o[i] = (m_mode[i] ? m_q[i] : fsum(i)) ^ ~m_pol[i];
            n[i] = (m_mode[i] || code == OE_TERM || code == 2'h3) ? ~terms.oe_term[i] : code == OE_OFF;
            t[i] = m_mode[i] ? ~m_q[i] : !n[i] ? o[i] : drv_en[i] ? drv_val[i] : 1'b1;
        end
        return {o, n, t, ~t};
    endfunction : calc

    // Reference register: clear, then preload, then set, then the sum term.
    always @(posedge pclk or negedge presetn or posedge terms.shared_async_clear_term) begin
        if (!presetn || terms.shared_async_clear_term) begin
            m_q <= '0;
            pl_go <= 1'b0;
        end else begin
            pl_go <= psel && penable && pwrite && paddr == ADDR_PRELOAD;
            pl_val <= pwdata[11:0];
            for (int i = 0; i < NUM_CELLS; i++) begin
                m_q[i] <= pl_go ? pl_val[i] : terms.shared_sync_set_term | fsum(i);
            end
        end
    end

    task automatic chk(input logic [47:0] exp, input logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (psel && penable && pready === 1'b1) begin
            chk(bus_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
        end
        if (cyc > 5000) begin
            num_errors++;
            complete_run();
        end
    end

    always @(pin_ev) begin
        chk(pin_q.pop_front(), {pin_out, pin_oe_n, array_fb.fb_true, array_fb.fb_comp});
    end

    task automatic look_pins(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
        pin_q.push_back(calc());
        -> pin_ev;
    endtask : look_pins

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [32:0] e);
        bus_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && a == ADDR_MODE) m_mode = d[11:0];
        if (wr && a == ADDR_POL) m_pol = d[11:0];
        if (wr && a == ADDR_OE) m_oe = d[23:0];
    endtask : apb

    task automatic shuffle();
        rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        terms <= {rnd[157:2], 2'b00};
        drv_en <= rnd[169:158];
        drv_val <= rnd[181:170];
    endtask : shuffle

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d.", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        terms = '0;
        drv_en = '0;
        drv_val = '0;
        m_mode = MODE_RST;
        m_pol = POL_RST;
        m_oe = OE_RST;
        void'($urandom(96176));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        look_pins(3);
        apb(0, ADDR_MODE, 0, {1'b0, 32'h0});
        apb(0, ADDR_POL, 0, {1'b0, 32'h0000_0FFF});
        apb(0, ADDR_OE, 0, {1'b0, 32'h00AA_AAAA});
        apb(1, 12'h020, 32'hFFFF_FFFF, {1'b1, 32'h0});
        apb(0, 12'h020, 0, {1'b1, 32'h0});
        $display("Reset and register test finished.");
        for (int k = 0; k < 8; k++) begin
            apb(1, ADDR_OE, {8'h0, {12{k[1:0]}}}, 33'h0);
            apb(1, ADDR_POL, $urandom, 33'h0);
            shuffle();
            look_pins(3);
        end
        $display("Combinatorial test finished.");
        apb(1, ADDR_MODE, 32'h0000_0FFF, 33'h0);
        for (int k = 0; k < 4; k++) begin
            shuffle();
            apb(1, ADDR_PRELOAD, $urandom, 33'h0);
            look_pins(1);
            look_pins(1);
        end
        // Sum held at zero so that only the set term can raise the registers.
        @(posedge pclk);
        terms.logic_term <= '0;
        terms.shared_sync_set_term <= 1'b1;
        look_pins(1);
        @(posedge pclk);
        terms.shared_sync_set_term <= 1'b0;
        terms.logic_term <= '1;
        @(posedge pclk);
        terms.shared_async_clear_term <= 1'b1;
        terms.shared_sync_set_term <= 1'b1;
        look_pins(0);
        look_pins(1);
        @(posedge pclk);
        terms.shared_async_clear_term <= 1'b0;
        terms.shared_sync_set_term <= 1'b0;
        look_pins(2);
        $display("Registered test finished.");
        complete_run();
    end
endmodule : tb_top
